// ### src/rdc_pkg.sv
// Shared constants, types and timing figures for the conversion sequencer.
// Assumes a single 200 MHz system clock and six simultaneously sampled
// channels.
package rdc_pkg;

  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int RDC_NCH        = 6;
  localparam int RDC_DW         = 16;
  localparam int RDC_BW         = 8;
  localparam int RDC_CHW        = 3;
  localparam int RDC_OSW        = 3;
  localparam int RDC_OS_MAX     = 6;
  localparam int RDC_SETW       = 7;
  localparam int RDC_ACCW       = 22;
  localparam int RDC_FIFO_DEPTH = 16;
  localparam int RDC_POSW       = 4;
  localparam int RDC_TMRW       = 10;
  localparam int RDC_BUSYCW     = 17;
  localparam int RDC_HALF_OFS   = 3;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int RDC_CLK_NS       = 5;
  localparam int RDC_SET_CONV_NS  = 3000;
  localparam int RDC_SET_CONV_CYC =
    (RDC_SET_CONV_NS + RDC_CLK_NS - 1) / RDC_CLK_NS;

  // ****************************************************************
  // Types and reset values
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_CONV = 3'h2,
    ST_LOAD = 3'h4
  } rdc_state_t;

  typedef struct packed {
    logic                 cva;
    logic                 cvb;
    logic [RDC_OSW-1:0]   os;
    logic                 cs_b;
    logic                 rd_b;
    logic                 sclk;
    logic                 par_ser;
    logic                 byte_sel;
    logic                 hi_first;
  } rdc_pins_t;

  localparam rdc_pins_t         RDC_PINS_RST = 11'h030;
  localparam logic [RDC_DW-1:0] RDC_RES_RST  = 16'h0000;
  localparam logic [RDC_OSW-1:0] RDC_OS_RST  = 3'h0;

endpackage

// ### src/rdc_smp_if.sv
// Sample stream between the input buffer and the averaging filter.
// Assumes both ends run on the system clock.
`timescale 1ns/100ps
interface rdc_smp_if;
  import rdc_pkg::*;
  logic                 vld;
  logic                 rdy;
  logic [RDC_CHW-1:0]   chan;
  logic [RDC_DW-1:0]    data;
  modport src (output vld, output chan, output data, input rdy);
  modport snk (input vld, input chan, input data, output rdy);
endinterface

// ### src/rdc_fifo.sv
// Generic synchronous FIFO with valid and ready on both sides.
// Assumes one clock; the ready toward the writer is registered.
`timescale 1ns/100ps
module rdc_fifo #(
  parameter int W = 19,
  parameter int D = 16
) (
  input  wire logic         sys_clk_i,
  input  wire logic         rst_b_i,
  input  wire logic         in_vld_i,
  input  wire logic [W-1:0] in_data_i,
  output logic              in_rdy_o,
  output logic              out_vld_o,
  output logic [W-1:0]      out_data_o,
  input  wire logic         out_rdy_i
);
  localparam int AW = $clog2(D);

  logic [W-1:0]  mem [D];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0]   cnt_ff;
  logic [AW:0]   nxt_cnt;
  logic          in_rdy_ff;
  logic          push;
  logic          pop;

  assign push       = in_vld_i && in_rdy_ff;
  assign pop        = out_vld_o && out_rdy_i;
  assign out_vld_o  = (cnt_ff != '0);
  assign out_data_o = mem[rd_ptr_ff];
  assign in_rdy_o   = in_rdy_ff;
  assign nxt_cnt    = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);

  // ****************************************************************
  // Storage
  // ****************************************************************
  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      mem[wr_ptr_ff] <= in_data_i;
    end
  end

  // ****************************************************************
  // Pointers and fill level
  // ****************************************************************
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      cnt_ff    <= '0;
      in_rdy_ff <= 1'b0;
    end else begin
      wr_ptr_ff <= wr_ptr_ff + AW'(push);
      rd_ptr_ff <= rd_ptr_ff + AW'(pop);
      cnt_ff    <= nxt_cnt;
      in_rdy_ff <= (nxt_cnt != (AW+1)'(D));
    end
  end

endmodule

// ### src/rdc_avg.sv
// Per-channel averaging filter over a power-of-two number of sample sets.
// Assumes the ratio input stays constant between start pulses.
`timescale 1ns/100ps
module rdc_avg
  import rdc_pkg::*;
(
  input  wire logic               sys_clk_i,
  input  wire logic               rst_b_i,
  input  wire logic               start_i,
  input  wire logic [RDC_OSW-1:0] ratio_i,
  rdc_smp_if.snk                  smp,
  output logic                    res_vld_o,
  output logic [RDC_CHW-1:0]      res_chan_o,
  output logic [RDC_DW-1:0]       res_data_o
);
  logic [RDC_ACCW-1:0] acc_ff [RDC_NCH];
  logic [RDC_SETW-1:0] cnt_ff [RDC_NCH];
  logic                phase_ff;
  logic                take;
  logic                chan_ok;
  logic                is_last;
  logic [RDC_SETW-1:0] sets_m1;
  logic [RDC_ACCW-1:0] base;
  logic [RDC_ACCW-1:0] sum;
  logic [RDC_ACCW-1:0] avg;

  // ****************************************************************
  // Accumulate and scale
  // ****************************************************************
  assign smp.rdy = !phase_ff;
  assign chan_ok = (smp.chan < RDC_CHW'(RDC_NCH));
  assign take    = smp.vld && !phase_ff && chan_ok;
  assign sets_m1 = RDC_SETW'((1 << ratio_i) - 1);
  assign is_last = chan_ok && (cnt_ff[smp.chan] == sets_m1);
  assign base    = (cnt_ff[smp.chan] == '0) ? '0 : acc_ff[smp.chan];
  assign sum     = base +
    {{(RDC_ACCW-RDC_DW){smp.data[RDC_DW-1]}}, smp.data};
  assign avg     = $signed(sum) >>> ratio_i;

  for (genvar c = 0; c < RDC_NCH; c++) begin : g_ch
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        acc_ff[c] <= '0;
        cnt_ff[c] <= '0;
      end else if (start_i) begin
        cnt_ff[c] <= '0;
      end else if (take && smp.chan == RDC_CHW'(c)) begin
        acc_ff[c] <= sum;
        cnt_ff[c] <= is_last ? '0 : cnt_ff[c] + 1'b1;
      end
    end
  end

  // ****************************************************************
  // Result output
  // ****************************************************************
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      phase_ff   <= 1'b0;
      res_vld_o  <= 1'b0;
      res_chan_o <= '0;
      res_data_o <= RDC_RES_RST;
    end else begin
      phase_ff   <= take;
      res_vld_o  <= take && is_last;
      res_chan_o <= smp.chan;
      res_data_o <= avg[RDC_DW-1:0];
    end
  end

  AST_PASS_THROUGH: assert property (
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    (take && ratio_i == '0) |=> res_vld_o && res_data_o == $past(smp.data))
    else $error("Unfiltered sample not passed through");

  AST_AVG_WAITS: assert property (
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    (take && ratio_i != '0 && cnt_ff[smp.chan] == '0) |=> !res_vld_o)
    else $error("Average emitted before all sets were summed");

endmodule

// ### src/rdc_ctrl.sv
// Conversion sequencer: busy timing, oversampling ratio latch, result
// registers and read-back in parallel, byte and serial modes.
// Assumes the core delivers channel-tagged samples after each set request.
//
// Functional notes
// - Reads while busy never disturb conversion
// - Reads during conversion return previous set
// - Read-back same at every ratio; word, byte or serial per mode
// - Results load one cycle before busy falls
// - Ratio pins latched when busy falls
// - Busy length scales with oversampling ratio
// - Oversampled data averaged before result storage
`timescale 1ns/100ps
module rdc_ctrl
  import rdc_pkg::*;
(
  input  wire logic               sys_clk_i,
  input  wire logic               rst_b_i,
  input  wire logic               conv_start_group_a_i,
  input  wire logic               conv_start_group_b_i,
  input  wire logic [RDC_OSW-1:0] oversample_ratio_pins_i,
  input  wire logic               cs_b_i,
  input  wire logic               rd_b_i,
  input  wire logic               sclk_i,
  input  wire logic               par_ser_sel_i,
  input  wire logic               byte_sel_i,
  input  wire logic               hi_byte_first_i,
  input  wire logic               sample_vld_i,
  input  wire logic [RDC_CHW-1:0] sample_chan_i,
  input  wire logic [RDC_DW-1:0]  sample_data_i,
  output logic                    sample_rdy_o,
  output logic                    sample_req_o,
  output logic                    busy_o,
  output logic [RDC_DW-1:0]       data_o,
  output logic                    data_oe_o,
  output logic                    first_data_o,
  output logic                    first_data_oe_o,
  output logic                    dout_a_o,
  output logic                    dout_b_o,
  output logic                    dout_oe_o
);
  rdc_pins_t                     pins_raw;
  rdc_pins_t                     pin_meta_ff;
  rdc_pins_t                     pin_sync_ff;
  rdc_pins_t                     pin_prev_ff;
  rdc_state_t                    state_ff;
  logic [RDC_OSW-1:0]            ratio_ff;
  logic [RDC_OSW-1:0]            os_sel;
  logic [RDC_TMRW-1:0]           tmr_ff;
  logic [RDC_SETW-1:0]           sets_left_ff;
  logic [RDC_CHW-1:0]            res_cnt_ff;
  logic [RDC_NCH-1:0][RDC_DW-1:0] conv_res_ff;
  logic [RDC_NCH-1:0][RDC_DW-1:0] out_res_ff;
  logic [RDC_POSW-1:0]           rd_pos_ff;
  logic [RDC_POSW-1:0]           ser_bit_ff;
  logic [RDC_CHW-1:0]            ser_ch_ff;
  logic [RDC_BUSYCW-1:0]         busy_cnt_ff;
  logic                          start;
  logic                          conv_done;
  logic                          rd_fall;
  logic                          sclk_fall;
  logic                          cs_rise;
  logic                          mode_ser;
  logic                          mode_byte;
  logic                          rd_last;
  logic [RDC_CHW-1:0]            rd_ch;
  logic [RDC_CHW-1:0]            ser_ch_b;
  logic [RDC_DW-1:0]             rd_word;
  logic                          fifo_vld;
  logic [RDC_CHW+RDC_DW-1:0]     fifo_q;
  logic                          res_vld;
  logic [RDC_CHW-1:0]            res_chan;
  logic [RDC_DW-1:0]             res_data;

  rdc_smp_if smp_if ();

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  assign pins_raw = {conv_start_group_a_i, conv_start_group_b_i,
                     oversample_ratio_pins_i, cs_b_i, rd_b_i, sclk_i,
                     par_ser_sel_i, byte_sel_i, hi_byte_first_i};

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pin_meta_ff <= RDC_PINS_RST;
      pin_sync_ff <= RDC_PINS_RST;
      pin_prev_ff <= RDC_PINS_RST;
    end else begin
      pin_meta_ff <= pins_raw;
      pin_sync_ff <= pin_meta_ff;
      pin_prev_ff <= pin_sync_ff;
    end
  end

  assign start     = pin_sync_ff.cva && pin_sync_ff.cvb &&
                     !(pin_prev_ff.cva && pin_prev_ff.cvb);
  assign os_sel    = (pin_sync_ff.os > RDC_OSW'(RDC_OS_MAX)) ?
                     RDC_OSW'(RDC_OS_MAX) : pin_sync_ff.os;
  assign mode_ser  = pin_sync_ff.par_ser && !pin_sync_ff.byte_sel;
  assign mode_byte = pin_sync_ff.par_ser && pin_sync_ff.byte_sel;
  assign cs_rise   = !pin_prev_ff.cs_b && pin_sync_ff.cs_b;
  assign rd_fall   = pin_prev_ff.rd_b && !pin_sync_ff.rd_b &&
                     !pin_sync_ff.cs_b && !mode_ser;
  assign sclk_fall = pin_prev_ff.sclk && !pin_sync_ff.sclk &&
                     !pin_sync_ff.cs_b && mode_ser;

  // ****************************************************************
  // Conversion sequence
  // ****************************************************************
  assign conv_done = (tmr_ff == '0) && (sets_left_ff == '0) &&
                     (res_cnt_ff == RDC_CHW'(RDC_NCH));

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_ff <= ST_IDLE;
    end else begin
      unique case (state_ff)
        ST_IDLE: begin
          if (start) begin
            state_ff <= ST_CONV;
          end
        end
        ST_CONV: begin
          if (conv_done) begin
            state_ff <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          state_ff <= ST_IDLE;
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      busy_o   <= 1'b0;
      ratio_ff <= RDC_OS_RST;
    end else if (state_ff == ST_IDLE && start) begin
      busy_o   <= 1'b1;
    end else if (state_ff == ST_LOAD) begin
      busy_o   <= 1'b0;
      ratio_ff <= os_sel;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tmr_ff       <= '0;
      sets_left_ff <= '0;
      sample_req_o <= 1'b0;
    end else if (state_ff == ST_IDLE && start) begin
      tmr_ff       <= RDC_TMRW'(RDC_SET_CONV_CYC - 1);
      sets_left_ff <= RDC_SETW'((1 << ratio_ff) - 1);
      sample_req_o <= 1'b1;
    end else if (state_ff == ST_CONV && tmr_ff != '0) begin
      tmr_ff       <= tmr_ff - 1'b1;
      sample_req_o <= 1'b0;
    end else if (state_ff == ST_CONV && sets_left_ff != '0) begin
      tmr_ff       <= RDC_TMRW'(RDC_SET_CONV_CYC - 1);
      sets_left_ff <= sets_left_ff - 1'b1;
      sample_req_o <= 1'b1;
    end else begin
      sample_req_o <= 1'b0;
    end
  end

  // ****************************************************************
  // Sample buffer and averaging filter
  // ****************************************************************
  rdc_fifo #(
    .W (RDC_CHW + RDC_DW),
    .D (RDC_FIFO_DEPTH)
  ) u_fifo (
    .sys_clk_i  (sys_clk_i),
    .rst_b_i    (rst_b_i),
    .in_vld_i   (sample_vld_i),
    .in_data_i  ({sample_chan_i, sample_data_i}),
    .in_rdy_o   (sample_rdy_o),
    .out_vld_o  (fifo_vld),
    .out_data_o (fifo_q),
    .out_rdy_i  (smp_if.rdy)
  );

  assign smp_if.vld  = fifo_vld;
  assign smp_if.chan = fifo_q[RDC_CHW+RDC_DW-1:RDC_DW];
  assign smp_if.data = fifo_q[RDC_DW-1:0];

  rdc_avg u_avg (
    .sys_clk_i  (sys_clk_i),
    .rst_b_i    (rst_b_i),
    .start_i    (state_ff == ST_IDLE && start),
    .ratio_i    (ratio_ff),
    .smp        (smp_if),
    .res_vld_o  (res_vld),
    .res_chan_o (res_chan),
    .res_data_o (res_data)
  );

  // ****************************************************************
  // Result staging and output registers
  // ****************************************************************
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      res_cnt_ff  <= '0;
      conv_res_ff <= {RDC_NCH{RDC_RES_RST}};
    end else if (state_ff == ST_IDLE && start) begin
      res_cnt_ff  <= '0;
    end else if (res_vld && res_chan < RDC_CHW'(RDC_NCH)) begin
      conv_res_ff[res_chan] <= res_data;
      res_cnt_ff  <= res_cnt_ff + 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      out_res_ff <= {RDC_NCH{RDC_RES_RST}};
    end else if (state_ff == ST_CONV && conv_done) begin
      out_res_ff <= conv_res_ff;
    end
  end

  // ****************************************************************
  // Parallel and byte read-back
  // ****************************************************************
  assign rd_ch   = mode_byte ? RDC_CHW'(rd_pos_ff >> 1) :
                   RDC_CHW'(rd_pos_ff);
  assign rd_last = mode_byte ?
                   (rd_pos_ff == RDC_POSW'(2 * RDC_NCH - 1)) :
                   (rd_pos_ff == RDC_POSW'(RDC_NCH - 1));
  assign rd_word = out_res_ff[rd_ch];

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rd_pos_ff <= '0;
    end else if (state_ff == ST_LOAD) begin
      rd_pos_ff <= '0;
    end else if (rd_fall) begin
      rd_pos_ff <= rd_last ? '0 : rd_pos_ff + 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      data_o <= RDC_RES_RST;
    end else if (rd_fall && mode_byte) begin
      data_o <= {{(RDC_DW-RDC_BW){1'b0}},
                 (rd_pos_ff[0] ^ pin_sync_ff.hi_first) ?
                 rd_word[RDC_DW-1:RDC_BW] : rd_word[RDC_BW-1:0]};
    end else if (rd_fall) begin
      data_o <= rd_word;
    end
  end

  // ****************************************************************
  // Serial read-back
  // ****************************************************************
  assign ser_ch_b = (ser_ch_ff < RDC_CHW'(RDC_HALF_OFS)) ?
                    ser_ch_ff + RDC_CHW'(RDC_HALF_OFS) :
                    ser_ch_ff - RDC_CHW'(RDC_HALF_OFS);

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ser_bit_ff <= '0;
      ser_ch_ff  <= '0;
    end else if (state_ff == ST_LOAD) begin
      ser_bit_ff <= '0;
      ser_ch_ff  <= '0;
    end else if (sclk_fall) begin
      ser_bit_ff <= ser_bit_ff + 1'b1;
      if (ser_bit_ff == '1) begin
        ser_ch_ff <= (ser_ch_ff == RDC_CHW'(RDC_NCH - 1)) ?
                     '0 : ser_ch_ff + 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      dout_a_o <= 1'b0;
      dout_b_o <= 1'b0;
    end else begin
      dout_a_o <= out_res_ff[ser_ch_ff][~ser_bit_ff];
      dout_b_o <= out_res_ff[ser_ch_b][~ser_bit_ff];
    end
  end

  // ****************************************************************
  // Output enables and first-channel flag
  // ****************************************************************
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      data_oe_o       <= 1'b0;
      dout_oe_o       <= 1'b0;
      first_data_oe_o <= 1'b0;
    end else begin
      data_oe_o       <= !pin_sync_ff.cs_b && !mode_ser;
      dout_oe_o       <= !pin_sync_ff.cs_b && mode_ser;
      first_data_oe_o <= !pin_sync_ff.cs_b;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      first_data_o <= 1'b0;
    end else if (mode_ser) begin
      first_data_o <= !pin_sync_ff.cs_b && (ser_ch_ff == '0);
    end else if (rd_fall) begin
      first_data_o <= (rd_ch == '0);
    end else if (cs_rise) begin
      first_data_o <= 1'b0;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      busy_cnt_ff <= '0;
    end else if (busy_o) begin
      busy_cnt_ff <= busy_cnt_ff + 1'b1;
    end else begin
      busy_cnt_ff <= '0;
    end
  end

  AST_READ_NO_DISTURB: assert property (
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    (state_ff == ST_CONV && rd_fall && tmr_ff != '0)
    |=> busy_o && tmr_ff == $past(tmr_ff) - 1'b1)
    else $error("Read disturbed the running conversion");

  AST_OLD_SET_HELD: assert property (
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    (state_ff == ST_CONV) |-> $stable(out_res_ff))
    else $error("Output results changed during conversion");

  AST_PAR_WORD: assert property (
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    (rd_fall && !pin_sync_ff.par_ser) |=> data_o == $past(rd_word))
    else $error("Parallel read returned the wrong word");

  AST_LOAD_BEFORE_FALL: assert property (
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    $changed(out_res_ff) |-> busy_o ##1 !busy_o)
    else $error("Results not loaded one cycle before busy fell");

  AST_RATIO_LATCH: assert property (
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    $fell(busy_o) |-> ratio_ff == $past(os_sel))
    else $error("Ratio not taken at busy falling edge");

  AST_BUSY_LEN: assert property (
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    $fell(busy_o)
    |-> busy_cnt_ff > (RDC_SET_CONV_CYC << $past(ratio_ff)))
    else $error("Busy shorter than the ratio demands");

  AST_START_BUSY: assert property (
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    (state_ff == ST_IDLE && start) |=> busy_o && sample_req_o)
    else $error("Start did not raise busy and request a set");

  AST_RATIO_HOLD: assert property (
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    (busy_o && $past(busy_o)) |-> $stable(ratio_ff))
    else $error("Ratio changed while busy");

endmodule

// ### dv/rdc_core_model.sv
// Behavioural sample core: six samples answer each set request.
// Assumes the bench clock; drives at the falling edge.
`timescale 1ns/100ps
module rdc_core_model
  import rdc_pkg::*;
(
  input  wire logic              sys_clk_i,
  input  wire logic              req_i,
  input  wire logic              rdy_i,
  input  wire logic              clr_i,
  input  wire logic [RDC_DW-1:0] base_i,
  output logic                   vld_o,
  output logic [RDC_CHW-1:0]     chan_o,
  output logic [RDC_DW-1:0]      data_o
);
  logic par;
  logic ok;
  initial begin
    vld_o = 1'b0;
    chan_o = 3'h7;
    data_o = 16'h0000;
    par = 1'b0;
  end
  always begin
    @(negedge sys_clk_i);
    if (clr_i === 1'b1) par = 1'b0;
    if (req_i === 1'b1) begin
      for (int c = 0; c < 6; c++) begin
        vld_o = 1'b1;
        chan_o = 3'(c);
        data_o = base_i + 16'(c) + (par ? 16'h0002 : 16'h0000);
        do begin
          ok = rdy_i;
          @(negedge sys_clk_i);
        end while (ok !== 1'b1);
      end
      par = ~par;
      vld_o = 1'b0;
      chan_o = ~chan_o;
      data_o = ~data_o;
    end
  end
endmodule

// ### dv/rdc_ctrl_bench.sv
// Bench for the conversion sequencer with a behavioural core.
// Assumes the package sizes and a 5 ns clock.
`timescale 1ns/100ps
module rdc_ctrl_bench;
  import rdc_pkg::*;
  logic        sys_clk_i, rst_b_i, cva, cvb, cs_b, rd_b, ps, bs, hf, clr, sck;
  logic [2:0]  os, chan;
  logic [15:0] base, sdat, dat;
  logic        vld, rdy, req, busy, doe, fd, fdoe, da, db, soe;
  int          err_count, total_checks, n, len;
  rdc_ctrl dut (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
    .conv_start_group_a_i(cva), .conv_start_group_b_i(cvb),
    .oversample_ratio_pins_i(os), .cs_b_i(cs_b), .rd_b_i(rd_b),
    .sclk_i(sck), .par_ser_sel_i(ps), .byte_sel_i(bs),
    .hi_byte_first_i(hf), .sample_vld_i(vld), .sample_chan_i(chan),
    .sample_data_i(sdat), .sample_rdy_o(rdy), .sample_req_o(req),
    .busy_o(busy), .data_o(dat), .data_oe_o(doe), .first_data_o(fd),
    .first_data_oe_o(fdoe), .dout_a_o(da), .dout_b_o(db),
    .dout_oe_o(soe));
  rdc_core_model core (.sys_clk_i(sys_clk_i), .req_i(req), .rdy_i(rdy),
    .clr_i(clr), .base_i(base), .vld_o(vld), .chan_o(chan),
    .data_o(sdat));
  // ****************************************************************
  // Clock and busy length
  // ****************************************************************
  initial begin
    sys_clk_i = 0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) begin
    if (busy === 1'b1) n <= n + 1;
    else if (n != 0) begin
      len <= n;
      n <= 0;
    end
  end
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic check(string nm, logic [15:0] s, logic [15:0] e);
    total_checks++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic go(logic [15:0] b);
    base = b;
    clr = 1;
    cva = 1;
    cvb = 1;
    repeat (2) @(negedge sys_clk_i);
    clr = 0;
    for (int i = 0; i < 20 && busy !== 1'b1; i++) @(negedge sys_clk_i);
    check("busy_up", 16'(busy), 16'h0001);
    cva = 0;
    cvb = 0;
  endtask
  task automatic fin(int r);
    for (int i = 0; i < 6000 && busy === 1'b1; i++) @(negedge sys_clk_i);
    repeat (2) @(negedge sys_clk_i);
    check("busy_down", 16'(busy), 16'h0000);
    check("busy_min", 16'(len >= (600 << r)), 16'h0001);
    check("busy_max", 16'(len < (1200 << r)), 16'h0001);
  endtask
  task automatic rd(logic [15:0] e);
    rd_b = 0;
    repeat (5) @(negedge sys_clk_i);
    check("data", dat, e);
    rd_b = 1;
    repeat (5) @(negedge sys_clk_i);
  endtask
  task automatic rd6(logic [15:0] b);
    cs_b = 0;
    repeat (4) @(negedge sys_clk_i);
    for (int c = 0; c < 6; c++) rd(b + 16'(c));
    check("oe", 16'(doe), 16'h0001);
    check("fdoe", 16'(fdoe), 16'h0001);
    cs_b = 1;
    repeat (4) @(negedge sys_clk_i);
  endtask
  task automatic rds(logic [15:0] ea, logic [15:0] eb);
    logic [15:0] a, b;
    a = 0;
    b = 0;
    cs_b = 0;
    repeat (4) @(negedge sys_clk_i);
    check("soe", 16'(soe), 16'h0001);
    check("first_s", 16'(fd), 16'h0001);
    for (int i = 0; i < 16; i++) begin
      a = {a[14:0], da};
      b = {b[14:0], db};
      sck = 0;
      repeat (4) @(negedge sys_clk_i);
      sck = 1;
      repeat (4) @(negedge sys_clk_i);
    end
    check("dout_a", a, ea);
    check("dout_b", b, eb);
    cs_b = 1;
    repeat (4) @(negedge sys_clk_i);
  endtask
  task automatic test_single_set();
    go(16'h1000);
    os = 3'h1;
    fin(0);
    rd6(16'h1000);
    $display("test single_set done");
  endtask
  task automatic test_read_in_busy();
    go(16'h2000);
    os = 3'h2;
    rd6(16'h1000);
    fin(1);
    rd6(16'h2001);
    $display("test read_in_busy done");
  endtask
  task automatic test_byte_mode();
    ps = 1;
    bs = 1;
    hf = 1;
    go(16'h3000);
    os = 3'h0;
    fin(2);
    cs_b = 0;
    repeat (4) @(negedge sys_clk_i);
    rd(16'h0030);
    check("first", 16'(fd), 16'h0001);
    rd(16'h0001);
    cs_b = 1;
    repeat (4) @(negedge sys_clk_i);
    $display("test byte_mode done");
  endtask
  task automatic test_serial();
    bs = 0;
    sck = 1;
    go(16'h4000);
    rds(16'h3001, 16'h3004);
    fin(0);
    $display("test serial done");
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ****************************************************************
  // Sequence
  // ****************************************************************
  initial begin
    #200000;
    err_count++;
    stop_test();
  end
  initial begin
    {rst_b_i, cva, cvb, os, ps, bs, hf, clr, sck} = 0;
    {cs_b, rd_b, base, err_count, total_checks} = 0;
    cs_b = 1;
    rd_b = 1;
    repeat (8) @(negedge sys_clk_i);
    rst_b_i = 1;
    repeat (4) @(negedge sys_clk_i);
    test_single_set();
    test_read_in_busy();
    test_byte_mode();
    test_serial();
    stop_test();
  end
endmodule
